// file: include/cnpr_pkg.sv
// Constants for the copper next-page register bank.
// Assumes a 16-bit register view placed in the low half of a 32-bit bus word.
package cnpr_pkg;
  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [3:0] IDX_EXP = 4'h6;
  localparam logic [3:0] IDX_NP_TX = 4'h7;
  localparam logic [3:0] IDX_LP_NP = 4'h8;
  localparam logic [3:0] IDX_GIG = 4'h9;
  localparam int ADDR_W = 6;

  // ****************************************
  // Expansion register fields
  // ****************************************
  localparam int EXP_PD_FAULT = 4;
  localparam int EXP_LP_NP_ABLE = 3;
  localparam int EXP_LOCAL_NP = 2;
  localparam int EXP_PAGE_RCVD = 1;
  localparam int EXP_LP_AN_ABLE = 0;
  localparam logic EXP_LOCAL_NP_RST = 1'h1;

  // ****************************************
  // Next page transmit fields
  // ****************************************
  localparam int NP_ACK = 14;
  localparam int NP_TOGGLE = 11;
  localparam logic [15:0] NP_WR_MASK = 16'hB7FF;
  localparam logic [15:0] NP_TX_RST = 16'h2001;
  localparam logic [15:0] LP_NP_RST = 16'h0000;

  // ****************************************
  // Gigabit control fields
  // ****************************************
  localparam int GIG_TM_LSB = 13;
  localparam int GIG_MANUAL = 12;
  localparam int GIG_MASTER = 11;
  localparam int GIG_PORT_TYPE = 10;
  localparam int GIG_ADV_FD = 9;
  localparam int GIG_ADV_HD = 8;
  localparam logic [4:0] GIG_UPD_RST = 5'h03;
  localparam logic [7:0] GIG_RES_RST = 8'h00;

  typedef enum logic [2:0] {
    CNPR_TM_NORMAL = 3'h0,
    CNPR_TM_WAVEFORM = 3'h1,
    CNPR_TM_MASTER_JITTER = 3'h2,
    CNPR_TM_SLAVE_JITTER = 3'h3,
    CNPR_TM_DISTORTION = 3'h4,
    CNPR_TM_RSVD5 = 3'h5,
    CNPR_TM_RSVD6 = 3'h6,
    CNPR_TM_RSVD7 = 3'h7
  } cnpr_test_mode_t;
endpackage : cnpr_pkg

// file: verification/cnpr_engine_model.sv
// Behavioural model of the auto-negotiation engine and copper link partner.
// Assumes the bench calls its tasks just after rising edges of clk_i.
`timescale 1ns/1ns
module cnpr_engine_model (
  input wire logic clk_i,
  input wire logic np_loaded_i,
  output logic pd_fault_o,
  output logic page_rcvd_o,
  output logic [15:0] rx_page_o,
  output logic lp_np_able_o,
  output logic lp_an_able_o,
  output logic page_ack_o,
  output logic page_sent_o
);
  int lag = 0;
  int loads = 0;
  // Idle values at time zero; page bus shows a non-page pattern
  initial
  begin
    {pd_fault_o, page_rcvd_o, lp_np_able_o, lp_an_able_o, page_ack_o, page_sent_o} = 6'h00;
    rx_page_o = 16'h5A5A;
  end
  // One-cycle parallel detection fault
  task automatic fault();
    @(posedge clk_i);
    pd_fault_o <= 1'b1;
    @(posedge clk_i);
    pd_fault_o <= 1'b0;
  endtask : fault
  // Page strobe with its code word; afterwards the bus is inverted so stale data never matches
  task automatic send_page(input logic [15:0] p);
    @(posedge clk_i);
    page_rcvd_o <= 1'b1;
    rx_page_o <= p;
    @(posedge clk_i);
    page_rcvd_o <= 1'b0;
    rx_page_o <= ~p;
  endtask : send_page
  task automatic set_lv(input logic np, input logic an, input logic ack);
    @(posedge clk_i);
    lp_np_able_o <= np;
    lp_an_able_o <= an;
    page_ack_o <= ack;
  endtask : set_lv
  // Each loaded page is sent lag + 1 cycles after the load strobe, so prompt and slow links both occur
  initial
  forever
  begin
    @(negedge clk_i);
    if (np_loaded_i === 1'b1)
    begin
      loads++;
      repeat (lag) @(posedge clk_i);
      @(posedge clk_i);
      page_sent_o <= 1'b1;
      @(posedge clk_i);
      page_sent_o <= 1'b0;
    end
  end
endmodule : cnpr_engine_model

// file: verification/cnpr_regs_bench.sv
// Self-checking bench for the copper next-page register bank.
// Assumes the engine model above and an Avalon-MM master built from tasks.
`timescale 1ns/1ns
module cnpr_regs_bench;
  logic core_clk, resetn, rd, wr, wait_o, tg;
  logic [5:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [3:0] be, evt;
  logic [15:0] tx_page;
  logic np_loaded, tclk, manual, master, prefer, fd, hd, pd, prc, npa, ana, ack, sent;
  logic [15:0] rx_page;
  logic [2:0] tmode;
  logic [3:0] tsel;
  int fails = 0;
  int n_compared = 0;
  cnpr_regs dut (.core_clk_i(core_clk), .resetn_i(resetn), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .sw_reset_i(evt[0]),
    .an_restart_i(evt[1]), .power_up_i(evt[2]), .link_down_i(evt[3]), .pd_fault_i(pd),
    .page_rcvd_i(prc), .rx_page_i(rx_page), .lp_np_able_i(npa), .lp_an_able_i(ana),
    .page_ack_i(ack), .page_sent_i(sent), .tx_page_o(tx_page), .np_loaded_o(np_loaded),
    .test_mode_o(tmode), .test_sel_o(tsel), .tx_clk_from_rx_o(tclk), .ms_manual_o(manual),
    .ms_master_o(master), .ms_prefer_master_o(prefer), .adv_1000fd_o(fd), .adv_1000hd_o(hd));
  cnpr_engine_model m (.clk_i(core_clk), .np_loaded_i(np_loaded), .pd_fault_o(pd),
    .page_rcvd_o(prc), .rx_page_o(rx_page), .lp_np_able_o(npa), .lp_an_able_o(ana),
    .page_ack_o(ack), .page_sent_o(sent));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", s, exp, got);
    end
  endtask : chk
  // Request stands until a rising edge samples waitrequest low; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do
    begin
      @(posedge core_clk);
    end
    while (wait_o !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rdx(input string s, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(s, q, e);
  endtask : rdx
  task automatic pulse(input int i);
    @(posedge core_clk);
    evt[i] <= 1'b1;
    @(posedge core_clk);
    evt[i] <= 1'b0;
  endtask : pulse
  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : settle
  task automatic results();
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  // ****************************************
  // Clock, reset and watchdog
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge core_clk);
    fails++;
    results();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    {resetn, rd, wr, evt, addr, wdata, tg} = 'h0;
    be = 4'hF;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    rdx("exp rst", 6'h18, 32'h0004);
    rdx("nptx rst", 6'h1C, 32'h2001);
    rdx("lpnp rst", 6'h20, 32'h0000);
    rdx("gig rst", 6'h24, 32'h0300);
    rdx("unmapped", 6'h3C, 32'h0000);
    bus(1'b1, 6'h18, 32'hFFFF);
    rdx("exp ro", 6'h18, 32'h0004);
    m.fault();
    rdx("pd set", 6'h18, 32'h0014);
    rdx("pd clr", 6'h18, 32'h0004);
    m.set_lv(1'b1, 1'b1, 1'b0);
    m.send_page(16'hA5C3);
    rdx("page rx", 6'h18, 32'h000F);
    rdx("lpnp", 6'h20, 32'h0000A5C3);
    bus(1'b1, 6'h20, 32'h0);
    rdx("lpnp ro", 6'h20, 32'h0000A5C3);
    rdx("page clr", 6'h18, 32'h000D);
    // Two loads, prompt then slow partner; toggle flips once per sent page
    m.set_lv(1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      m.lag = i * 5;
      bus(1'b1, 6'h1C, 32'hFFFF);
      settle(1);
      chk("tx word", tx_page, 16'hF7FF | (16'(tg) << 11));
      settle(10);
      tg = ~tg;
      chk("loads", m.loads, i + 1);
      rdx("toggle", 6'h1C, 32'hF7FF | (32'(tg) << 11));
    end
    m.set_lv(1'b0, 1'b0, 1'b0);
    pulse(3);
    rdx("link fail", 6'h1C, 32'h2001);
    // Every test mode code, then a restart back to normal
    for (int t = 0; t < 8; t++)
    begin
      bus(1'b1, 6'h24, (t << 13) | 32'h0300);
      settle(2);
      chk("tmode", tmode, t);
      chk("tsel", tsel, (t >= 1 && t <= 4) ? (4'h1 << (t - 1)) : 4'h0);
      chk("txclk", tclk, (t == 2 || t == 3));
    end
    pulse(1);
    settle(2);
    chk("tm restart", tmode, 3'h0);
    rdx("gig restart", 6'h24, 32'h0300);
    // Deferred master/slave and advertisement bits
    bus(1'b1, 6'h24, 32'h1C00);
    settle(3);
    chk("held", {manual, fd, hd}, 3'h3);
    rdx("shadow", 6'h24, 32'h1C00);
    pulse(2);
    settle(2);
    chk("manual", {manual, master, prefer, fd, hd}, 5'h18);
    bus(1'b1, 6'h24, 32'h0500);
    pulse(0);
    settle(2);
    chk("auto", {manual, master, prefer, fd, hd}, 5'h05);
    bus(1'b1, 6'h24, 32'h0300);
    pulse(3);
    settle(2);
    chk("link upd", {manual, master, prefer, fd, hd}, 5'h03);
    // Byte lanes: the upper lane alone, then the lower lane alone
    be <= 4'h2;
    bus(1'b1, 6'h24, 32'h1C55);
    be <= 4'h1;
    bus(1'b1, 6'h24, 32'hE0AA);
    be <= 4'hF;
    rdx("lanes", 6'h24, 32'h1CAA);
    settle(1);
    chk("lanes held", {manual, fd, hd}, 3'h3);
    results();
  end
endmodule : cnpr_regs_bench

// file: verilog/cnpr_regs.sv
// Copper auto-negotiation expansion, next page and gigabit control registers.
// Assumes an Avalon-MM master and an auto-negotiation engine on core_clk_i.
//
// Functional notes
// - Expansion bits 15:5 read zero and ignore writes.
// - Parallel detection fault sets a latched-high expansion bit 4.
// - Latched-high bits clear when software reads their register.
// - Expansion bit 3 shows link partner next-page ability.
// - Expansion bit 2 reads one: local device is next-page able.
// - New received page sets latched-high expansion bit 1.
// - Expansion bit 0 shows link partner auto-negotiation ability.
// - Any write to next page transmit signals page loaded, except in a cycle with link failure or software reset.
// - Copper link failure resets the next page transmit register.
// - Transmit register is outgoing code word; bits 14, 11 read-only.
// - Received next page stored bit for bit, read-only, reset zero.
// - Test modes 2 and 3 take transmit clock from receive clock.
// - Auto-negotiation restart clears test mode to normal.
// - Master/slave and advertise writes act only on update events.
// - Bit 12 set selects manual master/slave, clear selects automatic.
// - Manual selection: bit 11 set master, clear slave.
// - Port type preference ignored under manual selection.
// - Automatic: port type one prefers master, zero prefers slave.
// - Bits 9 and 8 advertise gigabit full and half duplex.
`timescale 1ns/1ns
module cnpr_regs (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sw_reset_i,
  input wire logic an_restart_i,
  input wire logic power_up_i,
  input wire logic link_down_i,
  input wire logic pd_fault_i,
  input wire logic page_rcvd_i,
  input wire logic [15:0] rx_page_i,
  input wire logic lp_np_able_i,
  input wire logic lp_an_able_i,
  input wire logic page_ack_i,
  input wire logic page_sent_i,
  output logic [15:0] tx_page_o,
  output logic np_loaded_o,
  output logic [2:0] test_mode_o,
  output logic [3:0] test_sel_o,
  output logic tx_clk_from_rx_o,
  output logic ms_manual_o,
  output logic ms_master_o,
  output logic ms_prefer_master_o,
  output logic adv_1000fd_o,
  output logic adv_1000hd_o
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
    logic pd_fault;
    logic page_rcvd;
    logic [15:0] np_tx;
    logic toggle;
    logic np_loaded;
    logic [15:0] lp_np;
    logic [2:0] test_mode;
    logic [4:0] gig_shadow;
    logic [7:0] gig_res;
    logic [4:0] gig_active;
  } cnpr_state_t;

  localparam cnpr_state_t ST_RST = '{
    ack: 1'b0,
    rdata: 16'h0000,
    pd_fault: 1'b0,
    page_rcvd: 1'b0,
    np_tx: cnpr_pkg::NP_TX_RST,
    toggle: 1'b0,
    np_loaded: 1'b0,
    lp_np: cnpr_pkg::LP_NP_RST,
    test_mode: cnpr_pkg::CNPR_TM_NORMAL,
    gig_shadow: cnpr_pkg::GIG_UPD_RST,
    gig_res: cnpr_pkg::GIG_RES_RST,
    gig_active: cnpr_pkg::GIG_UPD_RST
  };

  cnpr_state_t st;
  cnpr_state_t next_st;

  // ****************************************
  // Helpers
  // ****************************************
  // Map a byte address to a register index; unmapped gives zero
  function automatic logic [3:0] cnpr_index(input logic [5:0] addr);
    logic [3:0] idx;
    idx = addr[5:2];
    if (addr[1:0] != 2'h0 || idx < cnpr_pkg::IDX_EXP || idx > cnpr_pkg::IDX_GIG)
    begin
      idx = 4'h0;
    end
    return idx;
  endfunction : cnpr_index

  // One-hot test selection; reserved codes behave as normal operation
  function automatic logic [3:0] cnpr_test_decode(input logic [2:0] code);
    logic [3:0] sel;
    sel = 4'h0;
    unique case (cnpr_pkg::cnpr_test_mode_t'(code))
      cnpr_pkg::CNPR_TM_WAVEFORM: sel = 4'h1;
      cnpr_pkg::CNPR_TM_MASTER_JITTER: sel = 4'h2;
      cnpr_pkg::CNPR_TM_SLAVE_JITTER: sel = 4'h4;
      cnpr_pkg::CNPR_TM_DISTORTION: sel = 4'h8;
      cnpr_pkg::CNPR_TM_NORMAL, cnpr_pkg::CNPR_TM_RSVD5,
      cnpr_pkg::CNPR_TM_RSVD6, cnpr_pkg::CNPR_TM_RSVD7: sel = 4'h0;
    endcase
    return sel;
  endfunction : cnpr_test_decode

  logic [3:0] idx;
  logic rd_done;
  logic wr_done;
  logic [15:0] wmask;
  logic [15:0] wdata;
  logic upd_evt;
  logic [15:0] exp_view;
  logic [15:0] np_view;
  logic [15:0] gig_view;

  // Bus decode; a request completes in the cycle that ack is high
  assign idx = cnpr_index(avs_address_i);
  assign rd_done = avs_read_i & st.ack;
  assign wr_done = avs_write_i & st.ack;
  assign wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wdata = avs_writedata_i[15:0];
  assign upd_evt = sw_reset_i | an_restart_i | power_up_i | link_down_i;

  // Register views as software sees them
  assign exp_view = {11'h000, st.pd_fault, lp_np_able_i, cnpr_pkg::EXP_LOCAL_NP_RST,
                     st.page_rcvd, lp_an_able_i};
  assign np_view = {st.np_tx[15], page_ack_i, st.np_tx[13:12], st.toggle,
                    st.np_tx[10:0]};
  assign gig_view = {st.test_mode, st.gig_shadow, st.gig_res};

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_st = st;
    // Wait state: one cycle to snapshot read data, then release
    next_st.ack = (avs_read_i | avs_write_i) & ~st.ack;
    if ((avs_read_i & ~st.ack) == 1'b1)
    begin
      unique case (idx)
        cnpr_pkg::IDX_EXP: next_st.rdata = exp_view;
        cnpr_pkg::IDX_NP_TX: next_st.rdata = np_view;
        cnpr_pkg::IDX_LP_NP: next_st.rdata = st.lp_np;
        cnpr_pkg::IDX_GIG: next_st.rdata = gig_view;
        default: next_st.rdata = 16'h0000;
      endcase
    end
    // Clear only what the read reported, so an event after the snapshot survives
    if (rd_done && idx == cnpr_pkg::IDX_EXP)
    begin
      next_st.pd_fault = st.pd_fault & ~st.rdata[cnpr_pkg::EXP_PD_FAULT];
      next_st.page_rcvd = st.page_rcvd & ~st.rdata[cnpr_pkg::EXP_PAGE_RCVD];
    end
    // Software writes; the expansion and partner registers take none
    next_st.np_loaded = 1'b0;
    if (wr_done && idx == cnpr_pkg::IDX_NP_TX)
    begin
      next_st.np_tx = (st.np_tx & ~(wmask & cnpr_pkg::NP_WR_MASK)) |
                      (wdata & wmask & cnpr_pkg::NP_WR_MASK);
      next_st.np_loaded = 1'b1;
    end
    if (wr_done && idx == cnpr_pkg::IDX_GIG)
    begin
      if (avs_byteenable_i[1])
      begin
        next_st.test_mode = wdata[15:13];
        next_st.gig_shadow = wdata[12:8];
      end
      if (avs_byteenable_i[0])
      begin
        next_st.gig_res = wdata[7:0];
      end
    end
    // Toggle flips per page sent; acknowledge comes from the engine
    if (page_sent_i)
    begin
      next_st.toggle = ~st.toggle;
    end
    // Received page is stored as is
    if (page_rcvd_i)
    begin
      next_st.lp_np = rx_page_i;
    end
    // Restart forces normal operation, even over a write in the same cycle
    if (an_restart_i)
    begin
      next_st.test_mode = cnpr_pkg::CNPR_TM_NORMAL;
    end
    // Link failure and software reset empty the outgoing page
    if (link_down_i | sw_reset_i)
    begin
      next_st.np_tx = cnpr_pkg::NP_TX_RST;
      next_st.toggle = 1'b0;
      next_st.np_loaded = 1'b0;
    end
    if (sw_reset_i)
    begin
      next_st.lp_np = cnpr_pkg::LP_NP_RST;
      next_st.pd_fault = 1'b0;
      next_st.page_rcvd = 1'b0;
    end
    // Deferred bits: the newest software value becomes active on an event
    if (upd_evt)
    begin
      next_st.gig_active = next_st.gig_shadow;
    end
    // Hardware events win over a read clear in the same cycle
    if (pd_fault_i)
    begin
      next_st.pd_fault = 1'b1;
    end
    if (page_rcvd_i)
    begin
      next_st.page_rcvd = 1'b1;
    end
  end

  // Synchronous active-low reset loads hardware defaults
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      st <= ST_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Waitrequest is combinational so the first cycle of a request stalls
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st.ack;
  assign avs_readdata_o = {16'h0000, st.rdata};
  assign tx_page_o = np_view;
  assign np_loaded_o = st.np_loaded;
  assign test_mode_o = st.test_mode;
  assign test_sel_o = cnpr_test_decode(st.test_mode);
  assign tx_clk_from_rx_o = test_sel_o[1] | test_sel_o[2];
  // Active copy bits: [4] manual, [3] master value, [2] port type, [1] fd, [0] hd
  assign ms_manual_o = st.gig_active[4];
  assign ms_master_o = st.gig_active[4] & st.gig_active[3];
  assign ms_prefer_master_o = ~st.gig_active[4] & st.gig_active[2];
  assign adv_1000fd_o = st.gig_active[1];
  assign adv_1000hd_o = st.gig_active[0];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_exp_read;
    avs_read_i && !avs_waitrequest_o && idx == cnpr_pkg::IDX_EXP;
  endsequence

  sequence s_jitter_write;
    avs_write_i && !avs_waitrequest_o && idx == cnpr_pkg::IDX_GIG &&
      avs_byteenable_i[1] && avs_writedata_i[15:13] == 3'h2 && !an_restart_i;
  endsequence

  AST_EXP_UPPER_ZERO: assert property (s_exp_read |-> avs_readdata_o[15:5] == 11'h000)
    else $error("expansion upper bits not zero");
  AST_FAULT_LATCH: assert property (pd_fault_i |=> st.pd_fault ##1 (st.pd_fault ||
    ($past(rd_done) && $past(idx) == cnpr_pkg::IDX_EXP) || $past(sw_reset_i)))
    else $error("parallel fault not latched");
  AST_LH_CLEAR: assert property ((s_exp_read ##0 avs_readdata_o[4] && !pd_fault_i)
    |=> !st.pd_fault)
    else $error("fault bit not cleared by read");
  AST_LOCAL_NP: assert property (s_exp_read |-> avs_readdata_o[2])
    else $error("local next page able not reported");
  AST_PAGE_RCVD: assert property (page_rcvd_i |=> st.page_rcvd && st.lp_np == $past(rx_page_i))
    else $error("page received not latched");
  AST_NP_LOADED: assert property ((avs_write_i && !avs_waitrequest_o &&
    idx == cnpr_pkg::IDX_NP_TX && !link_down_i && !sw_reset_i) |=> np_loaded_o ##1 !np_loaded_o)
    else $error("page loaded not signalled once");
  AST_NP_CLEAR: assert property (link_down_i |=> tx_page_o[15] == 1'b0 &&
    tx_page_o[13:12] == 2'h2 && tx_page_o[10:0] == 11'h001 && !tx_page_o[11])
    else $error("transmit page not reset on link fail");
  AST_JITTER_CLK: assert property (s_jitter_write |=> tx_clk_from_rx_o || $past(an_restart_i))
    else $error("transmit clock not taken from receive clock");
  AST_TM_RESTART: assert property (an_restart_i |=> test_mode_o == 3'h0 && !tx_clk_from_rx_o)
    else $error("restart did not clear test mode");
  AST_DEFER: assert property (!upd_evt |=> $stable(st.gig_active))
    else $error("gigabit control acted without update event");
  AST_PREF_IGNORED: assert property ((upd_evt && !wr_done && st.gig_shadow[4])
    |=> ms_manual_o && !ms_prefer_master_o)
    else $error("port type used under manual selection");
  AST_TOGGLE: assert property ((page_sent_i && !link_down_i && !sw_reset_i)
    |=> tx_page_o[11] != $past(tx_page_o[11]))
    else $error("toggle did not flip on page sent");
endmodule : cnpr_regs
